// >>> rtl/codec_control_regs_one_two.sv
/*
 Control registers 1 and 2 of one codec channel, with mirroring of
 shadowed bits from the sibling channel and the decode of the pin
 configuration and bit-clock source.
 Assumes a host port front end that delivers one decoded 16-bit
 command with a one-cycle strobe, and converters that pulse overflow.
*/
//
// Operation
// - Read-only ADC overflow flag
// - Mode bit: programming or continuous transfer
// - Filter bit selects FIR or IIR
// - Read-only DAC overflow flag
// - Bias bit selects low or high level
// - Analog loopback bit enables loopback
// - Digital loopback bit enables loopback
// - Word-length bit: 16 or 15 DAC bits
// - 15-bit word with LSB one exits continuous
// - Slow clock: bit clock from frame rate
// - Fast clock: master clock divided by P
// - Bypass bit bypasses both filters
// - Three upper address bits, reset 100
// - Port config 00 two-wire, 01 start-stop
// - 10 drives GENERAL_OUTPUT_BIT, 11 forwards clock
// - Shadowed bits mirror from other channel
`timescale 1ns/1ps
`include "codec_ctrl_cfg.svh"

module codec_control_regs_one_two
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic shadow_wr_in,
   input wire logic [2:0] shadow_addr_in,
   input wire logic [7:0] shadow_data_in,
   output logic shadow_wr_out,
   output logic [2:0] shadow_addr_out,
   output logic [7:0] shadow_data_out,
   input wire logic adc_ovf_event,
   input wire logic adc_ovf_clear,
   input wire logic dac_ovf_event,
   input wire logic dac_ovf_clear,
   input wire logic dac_word_valid,
   input wire logic [15:0] dac_word,
   input wire logic [3:0] cascade_addr,
   input wire logic scl_in,
   input wire logic frame_flag,
   output logic continuous_transfer_sel,
   output logic filter_iir_sel,
   output logic bias_level_sel,
   output logic analog_loopback_en,
   output logic digital_loopback_en,
   output logic dac_word_length_sel,
   output logic [15:0] dac_sample,
   output logic dac_sample_valid,
   output logic fast_clock_sel,
   output logic filter_bypass,
   output logic [6:0] device_addr,
   output logic general_output_bit,
   output codec_ctrl_pkg::host_port_mode_t host_port_config,
   output logic sda_out,
   output logic sda_oe_n,
   output logic dout_forward,
   output logic dout_forward_en
);

   ////////////////////////////////////////////////////////////////////
   // Command decode

   logic [7:0] mode_reg;
   logic [7:0] mode_next;
   logic [7:0] port_reg;
   logic [7:0] port_next;
   logic adc_ovf_reg;
   logic dac_ovf_reg;

   // Register number sits in the top three command bits
   wire [2:0] cmd_addr = cmd_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
   wire cmd_read = cmd_word[`CMD_RW_BIT];
   wire host_wr = cmd_valid & ~cmd_read;
   wire host_rd = cmd_valid & cmd_read;
   wire wr_mode = host_wr & (cmd_addr == `REG_CODEC_MODE_FLAGS);
   wire wr_port = host_wr & (cmd_addr == `REG_PORT_CLOCK_CONFIG);
   wire sh_mode = shadow_wr_in & (shadow_addr_in == `REG_CODEC_MODE_FLAGS);
   wire sh_port = shadow_wr_in & (shadow_addr_in == `REG_PORT_CLOCK_CONFIG);

   // Shadow masks: which bits follow the sibling channel
   localparam logic [7:0] SH_MODE_MASK = 8'h49;
   localparam logic [7:0] SH_PORT_MASK = 8'hff;

   function automatic logic [7:0] merge
   (
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] mask
   );
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // A 15-bit word with LSB set ends continuous transfer
   wire cx_exit = dac_word_valid & mode_reg[`F_CONT_XFER]
      & ~mode_reg[`F_DAC_WORD_LEN] & dac_word[0];

   ////////////////////////////////////////////////////////////////////
   // Next-state of writable bits; a local write beats a mirror write

   always_comb
   begin
      mode_next = mode_reg;
      if (sh_mode)
         mode_next = merge(mode_next, shadow_data_in, SH_MODE_MASK);
      if (wr_mode)
         mode_next = merge(mode_next, cmd_word[7:0],
            ~`RO_MASK_MODE_FLAGS);
      if (cx_exit)
         mode_next[`F_CONT_XFER] = 1'b0;
      mode_next[`F_ADC_OVF] = 1'b0;
      mode_next[`F_DAC_OVF] = 1'b0;
      port_next = port_reg;
      if (sh_port)
         port_next = merge(port_next, shadow_data_in, SH_PORT_MASK);
      if (wr_port)
         port_next = cmd_word[7:0];
   end

   // Control registers take their defaults at reset
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_reg <= `RST_CODEC_MODE_FLAGS;
         port_reg <= `RST_PORT_CLOCK_CONFIG;
      end
      else
      begin
         mode_reg <= mode_next;
         port_reg <= port_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Overflow flags: set only by converters; set wins over clear

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         adc_ovf_reg <= 1'b0;
         dac_ovf_reg <= 1'b0;
      end
      else
      begin
         adc_ovf_reg <= adc_ovf_event | (adc_ovf_reg & ~adc_ovf_clear);
         dac_ovf_reg <= dac_ovf_event | (dac_ovf_reg & ~dac_ovf_clear);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path and mirror broadcast

   wire [7:0] mode_view = {adc_ovf_reg, mode_reg[6:5], dac_ovf_reg,
      mode_reg[3:0]};
   wire [7:0] rd_mux = (cmd_addr == `REG_CODEC_MODE_FLAGS) ? mode_view :
      (cmd_addr == `REG_PORT_CLOCK_CONFIG) ? port_reg : 8'h00;

   // Data outputs registered; unmapped numbers read zero
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         shadow_wr_out <= 1'b0;
         shadow_addr_out <= 3'h0;
         shadow_data_out <= 8'h00;
         dac_sample <= 16'h0000;
         dac_sample_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= host_rd;
         if (host_rd)
            rd_data <= rd_mux;
         shadow_wr_out <= wr_mode | wr_port;
         shadow_addr_out <= cmd_addr;
         shadow_data_out <= cmd_word[7:0];
         // Only data words pass; an exit word is swallowed
         dac_sample_valid <= dac_word_valid & mode_reg[`F_CONT_XFER]
            & ~cx_exit;
         if (dac_word_valid)
            dac_sample <= mode_reg[`F_DAC_WORD_LEN] ? dac_word :
               {dac_word[15:1], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control outputs

   assign continuous_transfer_sel = mode_reg[`F_CONT_XFER];
   assign filter_iir_sel = mode_reg[`F_FILTER_IIR];
   assign bias_level_sel = mode_reg[`F_BIAS_LEVEL];
   assign analog_loopback_en = mode_reg[`F_ANALOG_LB];
   assign digital_loopback_en = mode_reg[`F_DIGITAL_LB];
   assign dac_word_length_sel = mode_reg[`F_DAC_WORD_LEN];
   // Clock generator picks frame-based or divided master clock
   assign fast_clock_sel = port_reg[`F_FAST_CLOCK];
   assign filter_bypass = port_reg[`F_FILTER_BYPASS];
   assign device_addr = {port_reg[`F_ADDR_UPPER_HI:`F_ADDR_UPPER_LO],
      cascade_addr};
   assign general_output_bit = port_reg[`F_GP_OUT];
   assign host_port_config = codec_ctrl_pkg::host_port_mode_t'(
      port_reg[`F_PORT_CFG_HI:`F_PORT_CFG_LO]);

   // Pin routing; two-wire modes leave the data pin to the front end
   wire pin_gpo = host_port_config == codec_ctrl_pkg::port_gpo_on_data;
   wire pin_fwd = host_port_config == codec_ctrl_pkg::port_clock_forward;
   assign sda_out = pin_fwd ? frame_flag : general_output_bit;
   assign sda_oe_n = ~(pin_gpo | pin_fwd);
   assign dout_forward = pin_fwd & scl_in;
   assign dout_forward_en = pin_fwd;

   ////////////////////////////////////////////////////////////////////
   // Checks

   a_addr_reset: assert property (@(posedge ref_clk)
      $rose(rstn) |-> device_addr[6:4] == 3'b100)
      else $error("address bits not 100 after reset");
   a_mode_reset: assert property (@(posedge ref_clk)
      $rose(rstn) |-> mode_view == 8'h00)
      else $error("mode register not zero after reset");
   a_ovf_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_mode && !adc_ovf_event && !adc_ovf_reg |=> !adc_ovf_reg)
      else $error("host write set overflow flag");
   a_adc_ovf_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      adc_ovf_event |=> rd_mux[7] || cmd_addr != 3'h1)
      else $error("adc overflow not shown");
   a_dac_ovf_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      dac_ovf_event |=> dac_ovf_reg [*1])
      else $error("dac overflow flag not set");
   a_cx_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
      cx_exit |=> !continuous_transfer_sel && !dac_sample_valid)
      else $error("continuous mode not left");
   a_mode_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_mode && !cx_exit |=> filter_iir_sel == $past(cmd_word[5])
      && bias_level_sel == $past(cmd_word[3]))
      else $error("mode write not stored");
   a_port_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_port |=> port_reg == $past(cmd_word[7:0]))
      else $error("port write not stored");
   a_shadow_copy: assert property (@(posedge ref_clk) disable iff (!rstn)
      sh_port && !wr_port |=> port_reg == $past(shadow_data_in))
      else $error("shadow write not mirrored");
   a_read_data: assert property (@(posedge ref_clk) disable iff (!rstn)
      host_rd |=> rd_valid && rd_data == $past(rd_mux))
      else $error("read answer wrong");
   a_pin_gpo: assert property (@(posedge ref_clk) disable iff (!rstn)
      pin_gpo |-> !sda_oe_n && sda_out == general_output_bit)
      else $error("gpo not on data pin");

   c_cx_exit: cover property (@(posedge ref_clk) cx_exit);
   c_shadow: cover property (@(posedge ref_clk) sh_mode);
   c_read: cover property (@(posedge ref_clk) host_rd ##1 rd_valid);
   c_forward: cover property (@(posedge ref_clk) pin_fwd);

endmodule

// >>> include/codec_ctrl_cfg.svh
/*
 Offsets, field positions, reset values and command layout for the
 first two control registers of the dual-channel codec.
 Assumes inclusion by bare name from the design file.
*/
`ifndef CODEC_CTRL_CFG_SVH
`define CODEC_CTRL_CFG_SVH

// Register numbers carried in the command's top three bits
`define REG_CODEC_MODE_FLAGS 3'h1
`define REG_PORT_CLOCK_CONFIG 3'h2

// Command word layout
`define CMD_ADDR_HI 15
`define CMD_ADDR_LO 13
`define CMD_RW_BIT 12

// Mode/flags register fields
`define F_ADC_OVF 7
`define F_CONT_XFER 6
`define F_FILTER_IIR 5
`define F_DAC_OVF 4
`define F_BIAS_LEVEL 3
`define F_ANALOG_LB 2
`define F_DIGITAL_LB 1
`define F_DAC_WORD_LEN 0

// Port/clock register fields
`define F_FAST_CLOCK 7
`define F_FILTER_BYPASS 6
`define F_ADDR_UPPER_HI 5
`define F_ADDR_UPPER_LO 3
`define F_GP_OUT 2
`define F_PORT_CFG_HI 1
`define F_PORT_CFG_LO 0

// Reset values
`define RST_CODEC_MODE_FLAGS 8'h00
`define RST_PORT_CLOCK_CONFIG 8'h20

// Read-only bits of the mode/flags register
`define RO_MASK_MODE_FLAGS 8'h90

`endif

// >>> include/codec_ctrl_pkg.sv
/*
 Types shared by the control register bank.
 Assumes the constants header sits on the include path.
*/
package codec_ctrl_pkg;
   typedef enum logic [1:0]
   {
      port_i2c,
      port_start_stop,
      port_gpo_on_data,
      port_clock_forward
   } host_port_mode_t;
endpackage

// >>> tb/host_cmd_model.sv
/*
 Host side of the control port: turns one request into one command.
 Assumes requests are raised just after a rising edge for one cycle.
*/
`timescale 1ns/1ps
module host_cmd_model
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic go,
   input wire logic [2:0] reg_no,
   input wire logic rd,
   input wire logic [7:0] wdata,
   output logic cmd_valid,
   output logic [15:0] cmd_word
);
////////////////////////////////////////////////////////////////////////
   // Idle word flips each cycle so a stale word never passes for valid
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_valid <= 1'b0;
         cmd_word <= 16'h0000;
      end
      else
      begin
         cmd_valid <= go;
         cmd_word <= go ? {reg_no, rd, 4'h7, wdata} : ~cmd_word;
      end
   end
endmodule

// >>> tb/codec_control_regs_one_two_tb.sv
/*
 Self-checking bench for control registers 1 and 2 against an int model.
 Assumes the host model issues commands; converters and sibling faked.
*/
`timescale 1ns/1ps
module codec_control_regs_one_two_tb;
logic ref_clk = 0, rstn = 0, go = 0, rd = 0;
logic [2:0] reg_no = 0, shadow_addr_in = 0, shadow_addr_out;
logic [7:0] wdata = 0, shadow_data_in = 0, rd_data, shadow_data_out;
logic cmd_valid, rd_valid, shadow_wr_in = 0, shadow_wr_out;
logic [15:0] cmd_word, dac_word = 0, dac_sample;
logic adc_ovf_event = 0, adc_ovf_clear = 0, dac_ovf_event = 0;
logic dac_ovf_clear = 0, dac_word_valid = 0, scl_in = 0, frame_flag = 0;
logic [3:0] cascade_addr = 4'h5;
logic continuous_transfer_sel, filter_iir_sel, bias_level_sel;
logic analog_loopback_en, digital_loopback_en, dac_word_length_sel;
logic dac_sample_valid, fast_clock_sel, filter_bypass, general_output_bit;
logic [6:0] device_addr;
logic sda_out, sda_oe_n, dout_forward, dout_forward_en;
codec_ctrl_pkg::host_port_mode_t host_port_config;
int n_errors = 0, comparisons = 0, m1 = 0, m2 = 8'h20, i;
logic [31:0] s = 32'h0000_fef8;
////////////////////////////////////////////////////////////////////////
codec_control_regs_one_two codec_control_regs_one_two_i (.*);
host_cmd_model host_cmd_model_i (.ref_clk(ref_clk), .rstn(rstn),
   .go(go), .reg_no(reg_no), .rd(rd), .wdata(wdata),
   .cmd_valid(cmd_valid), .cmd_word(cmd_word));
// Half period of the 8 ns clock
always #4 ref_clk = ~ref_clk;
function automatic logic [31:0] xs(input logic [31:0] x);
   x = x ^ (x << 13);
   x = x ^ (x >> 17);
   return x ^ (x << 5);
endfunction
task automatic give_verdict();
   $display("errors %0d comparisons %0d", n_errors, comparisons);
   if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
endtask
task automatic chk(input string nm, input logic [15:0] seen,
   input logic [15:0] exp);
   comparisons++;
   if (seen !== exp)
   begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
   end
endtask
// Every register-driven level follows the model; data-pin levels only in modes 10 and 11
task automatic chk_outs();
   chk("cont", continuous_transfer_sel, m1[6]);
   chk("iir", filter_iir_sel, m1[5]);
   chk("bias", bias_level_sel, m1[3]);
   chk("aloop", analog_loopback_en, m1[2]);
   chk("dloop", digital_loopback_en, m1[1]);
   chk("wlen", dac_word_length_sel, m1[0]);
   chk("fast", fast_clock_sel, m2[7]);
   chk("bypass", filter_bypass, m2[6]);
   chk("dev_addr", device_addr, {m2[5:3], cascade_addr});
   chk("gp_out", general_output_bit, m2[2]);
   chk("port_cfg", host_port_config, m2[1:0]);
   chk("fwd_en", dout_forward_en, m2[1:0] == 3);
   if (m2[1])
   begin
      chk("sda_oe_n", sda_oe_n, 1'b0);
      chk("sda", sda_out, m2[0] ? frame_flag : m2[2]);
   end
   if (m2[1:0] == 3)
      chk("fwd", dout_forward, scl_in);
endtask
// One command through the host model; reads wait a bounded time
task automatic op(input logic [2:0] r, input logic rdn,
   input logic [7:0] d);
   int k;
   @(posedge ref_clk);
   go <= 1'b1;
   reg_no <= r;
   rd <= rdn;
   wdata <= d;
   @(posedge ref_clk);
   go <= 1'b0;
   if (!rdn && r == 1)
      m1 = (m1 & 8'h90) | (d & 8'h6f);
   if (!rdn && r == 2)
      m2 = d;
   @(posedge ref_clk);
   #1;
   if (!rdn && (r == 1 || r == 2))
      chk("shadow_wr", {shadow_wr_out, shadow_addr_out, shadow_data_out},
         {1'b1, r, d});
   else
      chk("shadow_idle", shadow_wr_out, 1'b0);
   if (!rdn)
      return;
   for (k = 0; k < 4 && rd_valid !== 1'b1; k++)
      @(posedge ref_clk) #1;
   if (k == 4)
   begin
      n_errors++;
      give_verdict();
   end
   chk("rd_data", rd_data, r == 1 ? m1 : r == 2 ? m2 : 0);
endtask
task automatic dac_try(input logic [15:0] w, input logic v,
   input logic [15:0] e);
   @(posedge ref_clk);
   dac_word_valid <= 1'b1;
   dac_word <= w;
   @(posedge ref_clk);
   dac_word_valid <= 1'b0;
   #1;
   chk("dac_v", dac_sample_valid, v);
   if (v)
      chk("dac", dac_sample, e);
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
   repeat (5) @(posedge ref_clk);
   rstn <= 1'b1;
   #1;
   chk("oe_n_rst", sda_oe_n, 1'b1);
   chk_outs();
   op(3'd1, 1'b1, 8'h00);
   op(3'd2, 1'b1, 8'h00);
   // Random writes cover all four pin configurations
   for (i = 0; i < 24; i++)
   begin
      s = xs(s);
      @(posedge ref_clk);
      scl_in <= s[0];
      frame_flag <= s[1];
      cascade_addr <= s[5:2];
      op(i[0] ? 3'd2 : 3'd1, 1'b0, i[0] ? {s[15:10], i[2:1]} : s[15:8]);
      chk_outs();
      op(i[0] ? 3'd2 : 3'd1, 1'b1, 8'h00);
   end
   op(3'd3, 1'b0, 8'hff);
   op(3'd3, 1'b1, 8'h00);
   // Flags set by converters, immune to writes, cleared by converters
   @(posedge ref_clk);
   {adc_ovf_event, dac_ovf_event} <= 2'b11;
   @(posedge ref_clk);
   {adc_ovf_event, dac_ovf_event} <= 2'b00;
   m1 = m1 | 8'h90;
   op(3'd1, 1'b0, 8'h00);
   op(3'd1, 1'b1, 8'h00);
   {adc_ovf_clear, dac_ovf_clear} <= 2'b11;
   @(posedge ref_clk);
   {adc_ovf_clear, dac_ovf_clear} <= 2'b00;
   m1 = m1 & 8'h6f;
   op(3'd1, 1'b1, 8'h00);
   // Sibling writes touch only shadowed bits
   shadow_wr_in <= 1'b1;
   shadow_addr_in <= 3'd1;
   shadow_data_in <= 8'hff;
   @(posedge ref_clk);
   shadow_wr_in <= 1'b0;
   m1 = m1 | 8'h49;
   op(3'd1, 1'b1, 8'h00);
   // Continuous mode: 16-bit words pass, 15-bit odd word leaves mode
   s = xs(s);
   op(3'd1, 1'b0, 8'h41);
   dac_try(s[15:0], 1'b1, s[15:0]);
   op(3'd1, 1'b0, 8'h40);
   dac_try(s[15:0] & 16'hfffe, 1'b1, s[15:0] & 16'hfffe);
   dac_try(s[15:0] | 16'h0001, 1'b0, 16'h0000);
   m1 = m1 & 8'hbf;
   chk_outs();
   give_verdict();
end
endmodule
